// [src/bsc_config_regs.sv]
// Burst shaping configuration bank behind an AXI4-Lite slave
//
// Function
// [RULE1] Width code 00, the reset value, gives 14-bit high phase at 25% duty.
// [RULE2] Width code 01 gives 12-bit at 50% duty; codes 10, 11 reserved.
// [RULE3] Sub-mode bit 0 clear selects stream, set selects trigger sub-mode.
// [RULE4] High phase lasts two to the phase-length value samples, reset ten.
// [RULE5] Software writes phase length only from 10 through 25.
// [RULE6] Shaper codes 00/01/10 centre at 0.25/0.29/0.21 Fs; 11 reserved.
// [RULE7] Software writes reserved upper bits of these registers as zero.
// [RULE8] Burst settings act only when source select is 1; else shaped data.
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_config_regs
    import bsc_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 28
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]         s_axi_awprot,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]         s_axi_arprot,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               sample_valid,
    input  wire logic               burst_trigger,
    output logic                    output_source_select,
    output logic                    burst_submode_select,
    output logic [4:0]              hires_sample_bits,
    output logic [6:0]              hires_duty_pct,
    output logic [7:0]              phase_length_exp,
    output logic [1:0]              shaper_center_select,
    output logic                    shaper_active,
    output logic                    burst_hires_phase
);

    // ****************************************************************
    // Addresses
    // ****************************************************************
    // Byte address is four times the register index
    localparam int             PAD = ADDR_W - 10;
    localparam logic [ADDR_W-1:0] A_SRC =
        {{PAD{1'b0}}, `BSC_IDX_SRC_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] A_CTRL1 =
        {{PAD{1'b0}}, `BSC_IDX_BURST_CTRL1, 2'b00};
    localparam logic [ADDR_W-1:0] A_LEN =
        {{PAD{1'b0}}, `BSC_IDX_BURST_LEN, 2'b00};
    localparam logic [ADDR_W-1:0] A_SHAPER =
        {{PAD{1'b0}}, `BSC_IDX_SHAPER_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] A_STATUS =
        {{PAD{1'b0}}, `BSC_IDX_STATUS, 2'b00};

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0]         src_ctrl_r,   src_ctrl_nxt;
    logic [7:0]         ctrl1_r,      ctrl1_nxt;
    logic [7:0]         len_r,        len_nxt;
    logic [7:0]         shaper_r,     shaper_nxt;
    logic               aw_have_r,    aw_have_nxt;
    logic [ADDR_W-1:0]  aw_addr_r,    aw_addr_nxt;
    logic               w_have_r,     w_have_nxt;
    logic [7:0]         w_byte_r,     w_byte_nxt;
    logic               w_lane_r,     w_lane_nxt;
    logic               bvalid_r,     bvalid_nxt;
    logic [1:0]         bresp_r,      bresp_nxt;
    logic               rvalid_r,     rvalid_nxt;
    logic [31:0]        rdata_r,      rdata_nxt;
    logic [1:0]         rresp_r,      rresp_nxt;
    logic [4:0]         bits_r,       bits_nxt;
    logic [6:0]         duty_r,       duty_nxt;
    logic [7:0]         status;
    logic               seq_hires;
    logic               seq_busy;
    logic               burst_en;
    logic               do_write;

    // Source select gates the phase sequencer; decoded burst settings stay live
    assign burst_en = src_ctrl_r[`BSC_SRC_SEL_BIT]; // [RULE8]

    // ****************************************************************
    // Phase sequencer
    // ****************************************************************
    bsc_burst_seq #(
        .CNT_W        (CNT_W)
    ) u_seq (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .enable       (burst_en),
        .trigger_mode (ctrl1_r[`BSC_SUBMODE_BIT]),
        .trigger      (burst_trigger),
        .sample_valid (sample_valid),
        .n_length     (len_r),
        .half_duty    (ctrl1_r[`BSC_WIDTH_LSB+1 -: 2]
                       == `BSC_WIDTH_12B_50PCT),
        .hires_phase  (seq_hires),
        .busy         (seq_busy)
    );

    // ****************************************************************
    // Status: flags for illegal programming, seen but not refused, and sequencer state
    // ****************************************************************
    always_comb begin
        // Live decodes: a flag clears once the value is rewritten
        status    = 8'h00;
        status[0] = ctrl1_r[`BSC_WIDTH_LSB+1]; // [RULE2]
        status[1] = (len_r < `BSC_NLEN_MIN)
                    || (len_r > `BSC_NLEN_MAX); // [RULE5]
        status[2] = (shaper_r[1:0] == `BSC_COEF_RESERVED); // [RULE6]
        status[3] = (ctrl1_r[7:`BSC_CTRL1_RSV_LSB] != 5'h00)
                    || (shaper_r[7:`BSC_SHAPER_RSV_LSB] != 6'h00); // [RULE7]
        status[4] = seq_hires;
        status[5] = seq_busy;
    end

    // ****************************************************************
    // Write channel: address and data taken in either order
    // ****************************************************************
    // Both readies drop while a response waits: one write at a time
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready  = !w_have_r && !bvalid_r;
    assign do_write      = aw_have_r && w_have_r && !bvalid_r;

    always_comb begin
        aw_have_nxt  = aw_have_r;
        aw_addr_nxt  = aw_addr_r;
        w_have_nxt   = w_have_r;
        w_byte_nxt   = w_byte_r;
        w_lane_nxt   = w_lane_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        src_ctrl_nxt = src_ctrl_r;
        ctrl1_nxt    = ctrl1_r;
        len_nxt      = len_r;
        shaper_nxt   = shaper_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            w_byte_nxt = s_axi_wdata[7:0];
            w_lane_nxt = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = `BSC_RESP_OKAY;
            // Values stored as written; illegal codes only show in status
            unique case (aw_addr_r)
                A_SRC: begin
                    if (w_lane_r) src_ctrl_nxt = w_byte_r;
                end
                A_CTRL1: begin
                    if (w_lane_r) ctrl1_nxt = w_byte_r;
                end
                A_LEN: begin
                    if (w_lane_r) len_nxt = w_byte_r;
                end
                A_SHAPER: begin
                    if (w_lane_r) shaper_nxt = w_byte_r;
                end
                A_STATUS: begin
                    bresp_nxt = `BSC_RESP_OKAY;
                end
                default: begin
                    bresp_nxt = `BSC_RESP_SLVERR;
                end
            endcase
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    // No new address while read data stand unclaimed
    assign s_axi_arready = !rvalid_r;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `BSC_RESP_OKAY;
            unique case (s_axi_araddr)
                A_SRC:    rdata_nxt = {24'h000000, src_ctrl_r};
                A_CTRL1:  rdata_nxt = {24'h000000, ctrl1_r};
                A_LEN:    rdata_nxt = {24'h000000, len_r};
                A_SHAPER: rdata_nxt = {24'h000000, shaper_r};
                A_STATUS: rdata_nxt = {24'h000000, status};
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = `BSC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // ****************************************************************
    // Decoded burst settings
    // ****************************************************************
    always_comb begin
        // Registered, so these outputs trail the register by one clock
        unique case (ctrl1_r[`BSC_WIDTH_LSB+1 -: 2])
            `BSC_WIDTH_14B_25PCT: begin
                bits_nxt = `BSC_BITS_WIDE; // [RULE1]
                duty_nxt = `BSC_DUTY_QUARTER; // [RULE1]
            end
            `BSC_WIDTH_12B_50PCT: begin
                bits_nxt = `BSC_BITS_NARROW; // [RULE2]
                duty_nxt = `BSC_DUTY_HALF; // [RULE2]
            end
            default: begin
                // Reserved codes fall back to the reset behaviour
                bits_nxt = `BSC_BITS_WIDE;
                duty_nxt = `BSC_DUTY_QUARTER;
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Synchronous reset: bus and sample strobes share this clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_ctrl_r <= `BSC_RST_SRC_CTRL;
            ctrl1_r    <= `BSC_RST_BURST_CTRL1;
            len_r      <= `BSC_RST_BURST_LEN; // [RULE4]
            shaper_r   <= `BSC_RST_SHAPER_CTRL;
            aw_have_r  <= 1'b0;
            aw_addr_r  <= '0;
            w_have_r   <= 1'b0;
            w_byte_r   <= 8'h00;
            w_lane_r   <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= 2'h0;
            rvalid_r   <= 1'b0;
            rdata_r    <= 32'h00000000;
            rresp_r    <= 2'h0;
            bits_r     <= `BSC_BITS_WIDE;
            duty_r     <= `BSC_DUTY_QUARTER;
        end else begin
            src_ctrl_r <= src_ctrl_nxt;
            ctrl1_r    <= ctrl1_nxt;
            len_r      <= len_nxt;
            shaper_r   <= shaper_nxt;
            aw_have_r  <= aw_have_nxt;
            aw_addr_r  <= aw_addr_nxt;
            w_have_r   <= w_have_nxt;
            w_byte_r   <= w_byte_nxt;
            w_lane_r   <= w_lane_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
            bits_r     <= bits_nxt;
            duty_r     <= duty_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_bvalid         = bvalid_r;
    assign s_axi_bresp          = bresp_r;
    assign s_axi_rvalid         = rvalid_r;
    assign s_axi_rdata          = rdata_r;
    assign s_axi_rresp          = rresp_r;
    assign output_source_select = burst_en; // [RULE8]
    assign burst_submode_select = ctrl1_r[`BSC_SUBMODE_BIT]; // [RULE3]
    assign hires_sample_bits    = bits_r;
    assign hires_duty_pct       = duty_r;
    assign phase_length_exp     = len_r; // [RULE4]
    assign shaper_center_select = shaper_r[1:0]; // [RULE6]
    assign shaper_active        = !burst_en; // [RULE8]
    assign burst_hires_phase    = seq_hires;

endmodule

// [src/bsc_params.svh]
// Offsets, field positions, reset values and limits of the burst config bank
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define BSC_IDX_SRC_CTRL     8'h70
`define BSC_IDX_BURST_CTRL1  8'h71
`define BSC_IDX_BURST_LEN    8'h73
`define BSC_IDX_SHAPER_CTRL  8'h78
`define BSC_IDX_STATUS       8'h7f

// ****************************************************************
// Reset values
// ****************************************************************
`define BSC_RST_SRC_CTRL     8'h20
`define BSC_RST_BURST_CTRL1  8'h00
`define BSC_RST_BURST_LEN    8'h0a
`define BSC_RST_SHAPER_CTRL  8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define BSC_SRC_SEL_BIT      0
`define BSC_SUBMODE_BIT      0
`define BSC_WIDTH_LSB        1
`define BSC_CTRL1_RSV_LSB    3
`define BSC_SHAPER_RSV_LSB   2

// ****************************************************************
// Field codes and limits
// ****************************************************************
`define BSC_WIDTH_14B_25PCT  2'h0
`define BSC_WIDTH_12B_50PCT  2'h1
`define BSC_COEF_RESERVED    2'h3
`define BSC_BITS_WIDE        5'h0e
`define BSC_BITS_NARROW      5'h0c
`define BSC_DUTY_QUARTER     7'h19
`define BSC_DUTY_HALF        7'h32
`define BSC_NLEN_MIN         8'h0a
`define BSC_NLEN_MAX         8'h19

// ****************************************************************
// Bus answers
// ****************************************************************
`define BSC_RESP_OKAY        2'h0
`define BSC_RESP_SLVERR      2'h2

`endif

// [src/bsc_pkg.sv]
// Types shared by the burst configuration bank and its phase sequencer
package bsc_pkg;

    typedef enum logic [1:0] {
        BSC_SEQ_IDLE  = 2'b00,
        BSC_SEQ_HIRES = 2'b01,
        BSC_SEQ_LORES = 2'b10
    } bsc_seq_state_t;

    typedef enum logic {
        BSC_SUB_STREAM  = 1'b0,
        BSC_SUB_TRIGGER = 1'b1
    } bsc_submode_t;

endpackage

// [src/bsc_burst_seq.sv]
// Burst phase sequencer: times high and low resolution phases in samples
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_burst_seq
    import bsc_pkg::*;
#(
    parameter int CNT_W = 28
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         enable,
    input  wire logic         trigger_mode,
    input  wire logic         trigger,
    input  wire logic         sample_valid,
    input  wire logic [7:0]   n_length,
    input  wire logic         half_duty,
    output logic              hires_phase,
    output logic              busy
);

    bsc_seq_state_t     state_r;
    bsc_seq_state_t     state_nxt;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   cnt_nxt;
    logic [7:0]         n_eff;
    logic [CNT_W-1:0]   hi_len;
    logic [CNT_W-1:0]   cyc_len;

    // ****************************************************************
    // Phase lengths
    // ****************************************************************
    always_comb begin
        // Clamp keeps illegal settings from running past the counter
        if (n_length < `BSC_NLEN_MIN) begin
            n_eff = `BSC_NLEN_MIN;
        end else if (n_length > `BSC_NLEN_MAX) begin
            n_eff = `BSC_NLEN_MAX;
        end else begin
            n_eff = n_length;
        end
        hi_len  = CNT_W'(1) << n_eff; // [RULE4]
        // 25% or 50% of the cycle is the high resolution phase
        cyc_len = half_duty ? (hi_len << 1) : (hi_len << 2); // [RULE1] [RULE2]
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (!enable) begin
            state_nxt = BSC_SEQ_IDLE; // [RULE8]
            cnt_nxt   = '0;
        end else begin
            unique case (state_r)
                BSC_SEQ_IDLE: begin
                    cnt_nxt = '0;
                    if (!trigger_mode || trigger) begin // [RULE3]
                        state_nxt = BSC_SEQ_HIRES;
                    end
                end
                BSC_SEQ_HIRES: begin
                    if (sample_valid) begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                        if (cnt_nxt >= hi_len) begin
                            state_nxt = BSC_SEQ_LORES;
                        end
                    end
                end
                BSC_SEQ_LORES: begin
                    if (sample_valid) begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                        if (cnt_nxt >= cyc_len) begin
                            cnt_nxt   = '0;
                            // Trigger mode runs one cycle per trigger
                            state_nxt = trigger_mode ? BSC_SEQ_IDLE
                                                     : BSC_SEQ_HIRES; // [RULE3]
                        end
                    end
                end
                default: begin
                    state_nxt = BSC_SEQ_IDLE;
                    cnt_nxt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= BSC_SEQ_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign hires_phase = (state_r == BSC_SEQ_HIRES);
    assign busy        = (state_r != BSC_SEQ_IDLE);

endmodule

// [tb/bsc_config_regs_asserts.sv]
// Port-level concurrent checks for the burst configuration bank
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_config_regs_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        output_source_select,
    input wire logic        shaper_active,
    input wire logic        burst_hires_phase,
    input wire logic [4:0]  hires_sample_bits,
    input wire logic [6:0]  hires_duty_pct
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************************************
    // Bus handshakes
    // ****************************************************************
    sequence write_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken_s;
        s_axi_arvalid && s_axi_arready;
    endsequence

    write_answer_a: assert property (
        write_taken_s |=> ##[0:2] s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (read_taken_s |=> s_axi_rvalid)
        else $error("read response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rdata_upper_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    write_refuse_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");

    // ****************************************************************
    // Output path
    // ****************************************************************
    shaper_route_a: assert property (
        shaper_active == !output_source_select)
        else $error("shaper path select wrong");
    hires_route_a: assert property (
        !output_source_select && !$past(output_source_select)
        |-> !burst_hires_phase)
        else $error("burst phase outside burst mode");
    width_pair_a: assert property (
        (hires_duty_pct == `BSC_DUTY_HALF)
        == (hires_sample_bits == `BSC_BITS_NARROW))
        else $error("bits and duty disagree");
    duty_legal_a: assert property (
        hires_duty_pct == `BSC_DUTY_QUARTER
        || hires_duty_pct == `BSC_DUTY_HALF)
        else $error("duty not quarter or half");
endmodule

// [tb/bsc_config_regs_test.sv]
// Bus-level self-checking bench for the burst configuration bank
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_config_regs_test;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        sample_valid = 1'b0, burst_trigger = 1'b0;
    logic        output_source_select, burst_submode_select;
    logic        shaper_active, burst_hires_phase;
    logic [4:0]  hires_sample_bits;
    logic [6:0]  hires_duty_pct;
    logic [7:0]  phase_length_exp;
    logic [1:0]  shaper_center_select;
    logic [7:0]  lens [3] = '{8'h19, 8'h11, 8'h0a};
    int          errors = 0, compares = 0, hi, lo;
    // Printed offsets are word indices, so byte address is four times
    localparam logic [11:0] A_SRC = 12'(`BSC_IDX_SRC_CTRL * 4);
    localparam logic [11:0] A_C1  = 12'(`BSC_IDX_BURST_CTRL1 * 4);
    localparam logic [11:0] A_LEN = 12'(`BSC_IDX_BURST_LEN * 4);
    localparam logic [11:0] A_SH  = 12'(`BSC_IDX_SHAPER_CTRL * 4);

    bsc_config_regs i_bsc_config_regs (.*);

    initial begin
        forever #4 aclk = ~aclk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task results;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Lag holds bready low a while so the response must stand
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s, input int lag);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n >= lag) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
        if (n >= 200) errors++;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, input int lag);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n >= lag) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
        if (n >= 200) errors++;
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr_rd(input logic [11:0] a, input logic [7:0] d);
        wr(a, d, 4'h1, 0);
        check(32'(rs), 32'h0);
        rd_reg(a, 0);
        check(32'(rs), 32'h0);
        check(rv, {24'h0, d});
    endtask

    // Skips any partial phase, then times one high and one low phase
    task automatic measure();
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        while (burst_hires_phase === 1'b1 && n < 5000) begin
            @(posedge aclk);
            n++;
        end
        while (burst_hires_phase !== 1'b1 && n < 10000) begin
            @(posedge aclk);
            n++;
        end
        while (burst_hires_phase === 1'b1 && hi < 5000) begin
            @(posedge aclk);
            hi++;
        end
        while (burst_hires_phase !== 1'b1 && lo < 5000) begin
            @(posedge aclk);
            lo++;
        end
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(A_SRC, 0);
        check(rv, 32'h20);
        rd_reg(A_C1, 3);
        check(rv, 32'h0);
        rd_reg(A_LEN, 0);
        check(rv, 32'h0a);
        rd_reg(A_SH, 0);
        check(rv, 32'h0);
        check(32'(phase_length_exp), 32'h0a);
        check(32'(shaper_active), 32'h1);
        check(32'(output_source_select), 32'h0);
        for (int i = 3; i >= 0; i--) begin
            wr_rd(A_C1, 8'(i));
            hi = i[1] ? 32'h0c : 32'h0e;
            lo = i[1] ? 32'h32 : 32'h19;
            check(32'(hires_sample_bits), hi);
            check(32'(hires_duty_pct), lo);
            check(32'(burst_submode_select), 32'(i[0]));
        end
        foreach (lens[i]) begin
            wr_rd(A_LEN, lens[i]);
            check(32'(phase_length_exp), 32'(lens[i]));
        end
        for (int i = 0; i < 3; i++) begin
            wr_rd(A_SH, 8'(i));
            check(32'(shaper_center_select), 32'(i));
        end
        wr(12'h100, 8'h5a, 4'h1, 4);
        check(32'(rs), 32'h2);
        rd_reg(12'h100, 0);
        check(rv, 32'h0);
        check(32'(rs), 32'h2);
        wr(A_SH, 8'h01, 4'h0, 0);
        rd_reg(A_SH, 0);
        check(rv, 32'h02);
        sample_valid <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr_rd(A_SRC, 8'h20);
            wr_rd(A_C1, 8'(2 * i));
            wr_rd(A_SRC, 8'h21);
            check(32'(shaper_active), 32'h0);
            check(32'(output_source_select), 32'h1);
            measure();
            check(hi, 32'h400);
            check(lo, i ? 32'h400 : 32'h0c00);
        end
        wr_rd(A_SRC, 8'h20);
        wr_rd(A_C1, 8'h01);
        wr_rd(A_SRC, 8'h21);
        hi = 0;
        repeat (100) begin
            @(posedge aclk);
            if (burst_hires_phase !== 1'b0) hi++;
        end
        check(hi, 32'h0);
        burst_trigger <= 1'b1;
        @(posedge aclk);
        burst_trigger <= 1'b0;
        measure();
        check(hi, 32'h400);
        check(lo, 32'h1388);
        wr_rd(A_SRC, 8'h20);
        check(32'(shaper_active), 32'h1);
        check(32'(burst_hires_phase), 32'h0);
        wr_rd(A_LEN, 8'h19);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(32'(phase_length_exp), 32'h0a);
        results();
    end

    // Tests need about 19k cycles; this allows over twice that
    initial begin
        #400000;
        errors++;
        results();
    end
endmodule

bind bsc_config_regs bsc_config_regs_chk i_bsc_config_regs_chk (.*);
